// >>> rccr_pkg.sv
package rccr_pkg;

  // ----------------------------------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_STATUS     = 12'h000;
  localparam logic [11:0] ADDR_VECBASE    = 12'h004;
  localparam logic [11:0] ADDR_SAVED      = 12'h008;
  localparam logic [11:0] ADDR_IRQFLAGS   = 12'h00C;
  localparam logic [11:0] ADDR_BKPT       = 12'h010;
  localparam logic [11:0] ADDR_EXEC_PC    = 12'h014;
  localparam logic [11:0] ADDR_DEC_PC     = 12'h018;
  localparam logic [11:0] ADDR_LEVEL_CTL  = 12'h01C;
  localparam logic [11:0] ADDR_GPR_BASE   = 12'h080;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int POS_REV_LO     = 28;
  localparam int POS_WIDE_MUL   = 22;
  localparam int POS_NARROW_MUL = 21;
  localparam int POS_OVF        = 15;
  localparam int POS_CARRY      = 14;
  localparam int POS_NEG        = 13;
  localparam int POS_ZERO       = 12;
  localparam int POS_PURGE      = 10;
  localparam int POS_FREEZE     = 9;
  localparam int POS_SQUASH     = 8;
  localparam int POS_BKPT_EN    = 5;
  localparam int POS_MASTER_EN  = 4;

  // revision value is arbitrary
  localparam logic [3:0]  CORE_REVISION     = 4'hA;
  localparam logic        WIDE_MUL_PRESENT  = 1'b0;
  localparam logic        NARROW_MUL_PRESENT = 1'b1;
  localparam logic [3:0]  LEVEL_RESET       = 4'hF;
  localparam logic [3:0]  LEVEL_USER        = 4'h0;
  localparam logic [31:0] VECBASE_MASK      = 32'hFFFFF000;
  localparam logic [31:0] WORD_MASK         = 32'hFFFFFFFC;
  localparam logic [31:0] LINK_STEP         = 32'h00000004;
  localparam int          VEC_SHIFT         = 4;
  localparam logic [7:0]  BKPT_VECTOR       = 8'h01;
  localparam logic [7:0]  PRIV_VECTOR       = 8'h02;
  localparam logic [7:0]  IRQ_VECTOR_BASE   = 8'h10;
  localparam logic [4:0]  REG_LINK          = 5'h00;
  localparam logic [4:0]  REG_SAVE_EXEC     = 5'h01;
  localparam logic [4:0]  REG_SAVE_DEC      = 5'h02;
  localparam logic [4:0]  REG_LONG_IMM      = 5'h03;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [31:0] data;
  } rccr_wb_t;

  typedef struct packed {
    logic        valid;
    logic        carry;
    logic        ovf;
    logic [31:0] result;
  } rccr_alu_t;

  typedef struct packed {
    logic        wr;
    logic [2:0]  sel;
    logic [31:0] data;
  } rccr_priv_wr_t;

  typedef struct packed {
    logic        take;
    logic [7:0]  vector;
    logic [31:0] entry;
  } rccr_event_t;

endpackage : rccr_pkg

// >>> rccr_core_regs.sv
// ----------------------------------------------------------------
// How it works
// - thirty-two 32-bit general registers, contents undefined after reset.
// - branch-and-link writes execute counter plus four into register 0.
// - accepted event copies execute counter to r1, decode counter to r2.
// - set-long-immediate writes its immediate into register 3.
// - privileged reads always allowed; level-0 writes suppressed, raise exception.
// - status top four bits hold fixed read-only revision code.
// - status bit 22 reads 0, bit 21 reads 1.
// - add/sub updates overflow, carry, negative, zero flags in bits 15..12.
// - writing purge bit invalidates icache, self-clears next cycle; purge at reset.
// - freeze bit holds icache contents; resets to 1.
// - squash bit nulls next instruction; not software settable; resets 0.
// - breakpoint enable plus address match traps before execution; resets 0.
// - master enable clears on acceptance, blocks further events, resets 0.
// - level field 0..15; interrupt accepted only if level strictly higher.
// - accepted interrupt sets processor level to its level; level resets 15.
// - vector base keeps upper 20 bits, lower 12 read zero.
// - entry address is vector base upper bits joined with vector shifted four.
// - acceptance saves status; saved upper half mirrors live status.
// - request flags show each wired level's pending source, regardless of level.
// - breakpoint address low two bits read zero.
// - execute counter reads word aligned.
// - decode counter reads word aligned.
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module rccr_core_regs
  import rccr_pkg::*;
#(
  parameter int IRQ_LEVELS = 16,
  parameter int IRQ_WIRED  = 6
)(
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  // apb slave
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [11:0]            PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  // pipeline
  input  wire logic [31:0]            EXEC_PC,
  input  wire logic [31:0]            DEC_PC,
  input  wire logic                   BRANCH_AND_LINK,
  input  wire logic                   SET_LONG_IMMEDIATE,
  input  wire logic [31:0]            LONG_IMM_VALUE,
  input  wire rccr_pkg::rccr_wb_t     WB,
  input  wire rccr_pkg::rccr_alu_t    ALU,
  input  wire rccr_pkg::rccr_priv_wr_t PRIV_WR,
  input  wire logic                   EXCEPTION_REQ,
  input  wire logic [7:0]             EXCEPTION_VECTOR,
  input  wire logic                   MASTER_ENABLE_SET,
  input  wire logic                   SQUASH_SET,
  input  wire logic                   INSTR_RETIRE,
  input  wire logic [IRQ_WIRED-1:0]   IRQ_LINES,
  // results
  output rccr_pkg::rccr_event_t       EVENT,
  output logic                        PRIV_FAULT,
  output logic                        ICACHE_PURGE,
  output logic                        ICACHE_FREEZE,
  output logic                        SQUASH_NEXT
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // request flags are one 16-bit word; only the wired part is fed
  if (IRQ_LEVELS != 16 || IRQ_WIRED < 1 || IRQ_WIRED > IRQ_LEVELS)
  begin : g_bad_levels
    $error("rccr_core_regs: unsupported interrupt level count");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        purge;
    logic        freeze;
    logic        squash;
    logic        bkpt_en;
    logic        master_en;
    logic [3:0]  level;
    logic        ovf;
    logic        carry;
    logic        neg;
    logic        zero;
    logic [15:0] saved_low;
    logic [31:0] vecbase;
    logic [31:0] bkpt;
    logic [15:0] irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    rccr_event_t ev;
    logic        fault;
  } rccr_state_t;

  rccr_state_t       st;
  rccr_state_t       next_st;
  logic [31:0]       gpr [32];

  logic [31:0]       status;
  logic [31:0]       saved;
  logic              bus_access;
  logic              bus_wr;
  logic [2:0]        bus_sel;
  logic              bus_priv_hit;
  logic              bkpt_hit;
  logic [4:0]        irq_best;
  logic              irq_take;
  logic              any_take;
  logic [31:0]       wr_data;
  logic              wr_en;
  logic [2:0]        wr_sel;

  // ----------------------------------------------------------------
  // status image
  // ----------------------------------------------------------------
  always_comb
  begin
    status = '0;
    status[31:POS_REV_LO]    = CORE_REVISION;
    status[POS_WIDE_MUL]     = WIDE_MUL_PRESENT;
    status[POS_NARROW_MUL]   = NARROW_MUL_PRESENT;
    status[POS_OVF]          = st.ovf;
    status[POS_CARRY]        = st.carry;
    status[POS_NEG]          = st.neg;
    status[POS_ZERO]         = st.zero;
    status[POS_PURGE]        = st.purge;
    status[POS_FREEZE]       = st.freeze;
    status[POS_SQUASH]       = st.squash;
    status[POS_BKPT_EN]      = st.bkpt_en;
    status[POS_MASTER_EN]    = st.master_en;
    status[3:0]              = st.level;
    saved = {status[31:16], st.saved_low};
  end

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_best = '0;
    for (int i = 0; i < IRQ_WIRED; i++)
    begin
      if (st.irq[i])
        irq_best = 5'(i + 1);
    end
  end

  assign bkpt_hit  = st.bkpt_en && ((EXEC_PC & WORD_MASK) == st.bkpt);
  assign irq_take  = st.master_en && ({1'b0, st.level} < irq_best);
  assign any_take  = st.master_en && (EXCEPTION_REQ || bkpt_hit || irq_take
                     || st.fault);

  // ----------------------------------------------------------------
  // register write path: pipeline first, bus when idle
  // ----------------------------------------------------------------
  assign bus_access   = PSEL && PENABLE && !st.pready;
  // a write lands on the completing edge, when the master sees ready
  assign bus_wr       = PSEL && PENABLE && PWRITE && st.pready;
  assign bus_sel      = PADDR[4:2];
  assign bus_priv_hit = PADDR[11:5] == ADDR_STATUS[11:5];

  always_comb
  begin
    wr_en   = PRIV_WR.wr;
    wr_sel  = PRIV_WR.sel;
    wr_data = PRIV_WR.data;
    if (!PRIV_WR.wr && bus_wr && bus_priv_hit)
    begin
      wr_en   = 1'b1;
      wr_sel  = bus_sel;
      wr_data = PWDATA;
    end
  end

  always_comb
  begin
    next_st          = st;
    next_st.pready   = 1'b0;
    next_st.pslverr  = 1'b0;
    next_st.ev       = '0;
    next_st.fault    = 1'b0;
    next_st.irq      = '0;
    next_st.irq[IRQ_WIRED-1:0] = IRQ_LINES;
    next_st.purge    = 1'b0;

    if (ALU.valid)
    begin
      next_st.ovf   = ALU.ovf;
      next_st.carry = ALU.carry;
      next_st.neg   = ALU.result[31];
      next_st.zero  = ALU.result == '0;
    end
    if (INSTR_RETIRE)
    begin
      next_st.squash = 1'b0;
    end
    if (SQUASH_SET)
    begin
      next_st.squash = 1'b1;
    end
    if (MASTER_ENABLE_SET)
    begin
      next_st.master_en = 1'b1;
    end

    if (wr_en && st.level == LEVEL_USER)
    begin
      next_st.fault = 1'b1;
    end
    else if (wr_en)
    begin
      case (wr_sel)
        3'h0:
        begin
          // only writable fields move; flags and squash keep hardware value
          next_st.purge     = wr_data[POS_PURGE];
          next_st.freeze    = wr_data[POS_FREEZE];
          next_st.bkpt_en   = wr_data[POS_BKPT_EN];
          next_st.master_en = wr_data[POS_MASTER_EN];
          next_st.level     = wr_data[3:0];
        end
        3'h1:
        begin
          next_st.vecbase   = wr_data & VECBASE_MASK;
        end
        3'h2:
        begin
          next_st.saved_low = wr_data[15:0];
        end
        3'h4:
        begin
          next_st.bkpt      = wr_data & WORD_MASK;
        end
        default: ;
      endcase
    end

    // acceptance after any software write of the same cycle
    if (any_take)
    begin
      next_st.saved_low  = status[15:0];
      next_st.master_en  = 1'b0;
      next_st.ev.take    = 1'b1;
      // a suppressed write is the oldest cause, so it goes first
      if (st.fault)
      begin
        next_st.ev.vector = PRIV_VECTOR;
      end
      else if (EXCEPTION_REQ)
      begin
        next_st.ev.vector = EXCEPTION_VECTOR;
      end
      else if (bkpt_hit)
      begin
        next_st.ev.vector = BKPT_VECTOR;
      end
      else
      begin
        next_st.ev.vector = IRQ_VECTOR_BASE + 8'(irq_best);
        next_st.level     = irq_best[3:0];
      end
      next_st.ev.entry = {st.vecbase[31:12], 12'(next_st.ev.vector) << VEC_SHIFT};
    end

    // bus answer: access phase with one wait state, ready on the following edge
    if (bus_access)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      if (PADDR[11:7] == ADDR_GPR_BASE[11:7])
        next_st.prdata = gpr[PADDR[6:2]];
      else if (!bus_priv_hit || PADDR[1:0] != 2'h0)
        next_st.pslverr = 1'b1;
      else
      begin
        case (bus_sel)
          3'h0:
          begin
            next_st.prdata = status;
          end
          3'h1:
          begin
            next_st.prdata = st.vecbase;
          end
          3'h2:
          begin
            next_st.prdata = saved;
          end
          3'h3:
          begin
            next_st.prdata = {16'h0000, st.irq};
          end
          3'h4:
          begin
            next_st.prdata = st.bkpt;
          end
          3'h5:
          begin
            next_st.prdata = EXEC_PC & WORD_MASK;
          end
          3'h6:
          begin
            next_st.prdata = DEC_PC & WORD_MASK;
          end
          3'h7:
          begin
            next_st.prdata = {28'h0000000, st.level};
          end
          default:
          begin
            next_st.prdata = '0;
          end
        endcase
        if (PWRITE && bus_sel == 3'h7)
        begin
          next_st.pslverr = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st           <= '0;
      st.freeze    <= 1'b1;
      st.purge     <= 1'b1;
      st.level     <= LEVEL_RESET;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // general registers
  // ----------------------------------------------------------------
  // general registers hold no reset: contents undefined until written
  always_ff @(posedge CLK)
  begin
    if (any_take)
    begin
      gpr[REG_SAVE_EXEC] <= EXEC_PC & WORD_MASK;
      gpr[REG_SAVE_DEC]  <= DEC_PC & WORD_MASK;
    end
    if (BRANCH_AND_LINK)
    begin
      gpr[REG_LINK] <= (EXEC_PC & WORD_MASK) + LINK_STEP;
    end
    if (SET_LONG_IMMEDIATE)
    begin
      gpr[REG_LONG_IMM] <= LONG_IMM_VALUE;
    end
    if (WB.valid && !BRANCH_AND_LINK && !SET_LONG_IMMEDIATE)
    begin
      gpr[WB.dest] <= WB.data;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state flops
  // ----------------------------------------------------------------
  assign PRDATA        = st.prdata;
  assign PREADY        = st.pready;
  assign PSLVERR       = st.pslverr;
  assign EVENT         = st.ev;
  assign PRIV_FAULT    = st.fault;
  assign ICACHE_PURGE  = st.purge;
  assign ICACHE_FREEZE = st.freeze;
  assign SQUASH_NEXT   = st.squash;

endmodule : rccr_core_regs

`default_nettype wire

// >>> rccr_irq_src.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------
// external interrupt sources
// ------------------------------------------
module rccr_irq_src
  import rccr_pkg::*;
(
  // core side
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire rccr_pkg::rccr_event_t ev,
  // bench commands
  input  wire logic                  raise,
  input  wire logic [2:0]            idx,
  output logic      [5:0]            lines
);
  // a source keeps its line up until the core accepts that level
  always_ff @(posedge clk)
  begin
    if (rst)
      lines <= 6'h00;
    else if (raise)
      lines <= lines | (6'h01 << idx);
    else if (ev.take && ev.vector > IRQ_VECTOR_BASE)
      lines <= lines & ~(6'h01 << (ev.vector - IRQ_VECTOR_BASE - 8'h01));
  end
endmodule : rccr_irq_src
`default_nettype wire

// >>> rccr_core_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rccr_core_regs_checker
  import rccr_pkg::*;
#(
  parameter int IRQ_WIRED = 6
)(
  // apb
  input  wire logic                    CLK,
  input  wire logic                    SYS_RST,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic                    PREADY,
  input  wire logic                    PSLVERR,
  // core
  input  wire rccr_pkg::rccr_priv_wr_t PRIV_WR,
  input  wire logic                    EXCEPTION_REQ,
  input  wire logic [IRQ_WIRED-1:0]    IRQ_LINES,
  input  wire rccr_pkg::rccr_event_t   EVENT,
  input  wire logic                    PRIV_FAULT,
  input  wire logic                    ICACHE_PURGE,
  input  wire logic                    ICACHE_FREEZE,
  input  wire logic                    SQUASH_NEXT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("access not answered after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_ready_idle: assert property (!PSEL |=> !PREADY)
    else $error("ready without a selected transfer");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error response without ready");
  a_purge_once: assert property (ICACHE_PURGE |=> !ICACHE_PURGE)
    else $error("purge did not clear after one cycle");
  a_reset_vals: assert property ($fell(SYS_RST) |-> ICACHE_FREEZE && !SQUASH_NEXT && !EVENT.take)
    else $error("wrong state after reset release");
  a_event_once: assert property (EVENT.take |=> !EVENT.take)
    else $error("second event accepted while enable is clear");
  a_entry_low: assert property (EVENT.take |-> EVENT.entry[11:0] == {EVENT.vector, 4'h0})
    else $error("entry offset differs from vector times sixteen");
  a_irq_cause: assert property (EVENT.take && EVENT.vector > IRQ_VECTOR_BASE && !$past(EXCEPTION_REQ)
    |-> $past(IRQ_LINES, 2) != '0)
    else $error("interrupt event without a request line");
  a_fault_cause: assert property ($rose(PRIV_FAULT)
    |-> $past(PSEL && PWRITE) || $past(PRIV_WR.wr) || $past(PRIV_WR.wr, 2))
    else $error("privilege fault without a write");

  c_fault_event: cover property (EVENT.take && EVENT.vector == PRIV_VECTOR);
  c_irq_event: cover property (EVENT.take && EVENT.vector > IRQ_VECTOR_BASE);
  c_slverr: cover property (PSLVERR);
  c_bkpt_event: cover property (EVENT.take && EVENT.vector == BKPT_VECTOR);
endmodule : rccr_core_regs_checker
`default_nettype wire

// >>> rccr_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rccr_pkg::*;
  logic          clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic          bal = 1'b0, set_long_immediate = 1'b0, meset = 1'b0, raise = 1'b0, prdy, perr;
  logic          sqs = 1'b0, ret = 1'b0, exc = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwd = '0, exec_pc = '0, dec_pc = '0, imm = '0, prd, v, pc, d;
  logic [2:0]    idx = 3'h0;
  logic [5:0]    irq;
  rccr_wb_t      wb = '0;
  rccr_alu_t     alu = '0;
  rccr_priv_wr_t pw = '0;
  rccr_event_t   ev;
  logic [32:0]   q_rd[$];
  logic [39:0]   q_ev[$];
  int            fails = 0, checked = 0, cyc = 0;

  rccr_core_regs u_dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .EXEC_PC(exec_pc), .DEC_PC(dec_pc),
    .BRANCH_AND_LINK(bal), .SET_LONG_IMMEDIATE(set_long_immediate), .LONG_IMM_VALUE(imm), .WB(wb), .ALU(alu),
    .PRIV_WR(pw), .EXCEPTION_REQ(exc), .EXCEPTION_VECTOR(8'h05), .MASTER_ENABLE_SET(meset),
    .SQUASH_SET(sqs), .INSTR_RETIRE(ret), .IRQ_LINES(irq), .EVENT(ev), .PRIV_FAULT(),
    .ICACHE_PURGE(), .ICACHE_FREEZE(), .SQUASH_NEXT());
  rccr_irq_src u_src (.clk(clk), .rst(rst), .ev(ev), .raise(raise), .idx(idx), .lines(irq));

  initial
  begin
    forever #2 clk = ~clk;
  end

  // ------------------------------------------
  // bus master and result checks
  // ------------------------------------------
  // an idle edge closes every transfer so no signal is driven twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dt);
    begin
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= dt;
      @(posedge clk);
      pen <= 1'b1;
      // wait as long as it takes; only the bench timeout ends a hang
      do
      begin
        @(posedge clk);
      end
      while (prdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic e, input logic [31:0] x);
    q_rd.push_back({e, x});
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got[32] !== exp[32] || (exp[32] === 1'b0 && got[31:0] !== exp[31:0]))
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_ev(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_ev

  task automatic complete_run();
    cmp_ev(40'(q_ev.size()), 40'h0);
    cmp_rd(33'(q_rd.size()), 33'h0);
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    if (prdy === 1'b1 && pwr === 1'b0)
      cmp_rd({perr, prd}, q_rd.size() > 0 ? q_rd.pop_front() : 33'hx);
    if (ev.take === 1'b1)
      cmp_ev({ev.vector, ev.entry}, q_ev.size() > 0 ? q_ev.pop_front() : 40'hx);
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      complete_run();
    end
  end

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  initial
  begin
    v = $urandom(99852);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_STATUS, 1'b0, 32'hA020020F);
    xfer(1'b1, ADDR_BKPT, 32'hFFFFFFFF);
    rd(ADDR_BKPT, 1'b0, 32'hFFFFFFFC);
    v = $urandom;
    xfer(1'b1, ADDR_VECBASE, v);
    rd(ADDR_VECBASE, 1'b0, v & VECBASE_MASK);
    xfer(1'b1, ADDR_STATUS, 32'hFFFFFFDF);
    rd(ADDR_STATUS, 1'b0, 32'hA020021F);
    for (int i = 0; i < 2; i++)
    begin
      alu <= i ? rccr_alu_t'({1'b1, 1'b0, 1'b1, 32'h80000000}) : rccr_alu_t'({1'b1, 1'b1, 1'b0, 32'h0});
      @(posedge clk);
      alu <= '0;
      @(posedge clk);
      rd(ADDR_STATUS, 1'b0, i ? 32'hA020A21F : 32'hA020521F);
    end
    pc = $urandom & WORD_MASK;
    d = $urandom;
    exec_pc <= pc;
    dec_pc <= pc + 32'h5;
    imm <= ~d;
    bal <= 1'b1;
    @(posedge clk);
    bal <= 1'b0;
    set_long_immediate <= 1'b1;
    @(posedge clk);
    set_long_immediate <= 1'b0;
    wb <= rccr_wb_t'({1'b1, 5'h07, d});
    @(posedge clk);
    wb <= '0;
    rd(ADDR_GPR_BASE, 1'b0, pc + LINK_STEP);
    rd(ADDR_GPR_BASE + 12'h00C, 1'b0, ~d);
    rd(ADDR_GPR_BASE + 12'h01C, 1'b0, d);
    rd(ADDR_EXEC_PC, 1'b0, pc);
    rd(ADDR_DEC_PC, 1'b0, pc + 32'h4);
    // level 6 must wait while the core runs at level 15
    dec_pc <= pc + 32'h4;
    idx <= 3'h5;
    raise <= 1'b1;
    @(posedge clk);
    raise <= 1'b0;
    rd(ADDR_IRQFLAGS, 1'b0, 32'h00000020);
    q_ev.push_back({IRQ_VECTOR_BASE + 8'h06, v[31:12], 12'h160});
    xfer(1'b1, ADDR_STATUS, 32'h00000213);
    repeat (4) @(posedge clk);
    rd(ADDR_SAVED, 1'b0, 32'hA020A213);
    rd(ADDR_STATUS, 1'b0, 32'hA020A206);
    rd(ADDR_GPR_BASE + 12'h004, 1'b0, pc);
    rd(ADDR_GPR_BASE + 12'h008, 1'b0, pc + 32'h4);
    rd(ADDR_IRQFLAGS, 1'b0, 32'h0);
    // set and retire in one cycle: set must win
    sqs <= 1'b1;
    ret <= 1'b1;
    @(posedge clk);
    sqs <= 1'b0;
    ret <= 1'b0;
    rd(ADDR_STATUS, 1'b0, 32'hA020A306);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    xfer(1'b1, ADDR_BKPT, pc);
    q_ev.push_back({BKPT_VECTOR, v[31:12], 12'h010});
    xfer(1'b1, ADDR_STATUS, 32'h00000236);
    exec_pc <= pc + 32'h8;
    rd(ADDR_STATUS, 1'b0, 32'hA020A226);
    q_ev.push_back({8'h05, v[31:12], 12'h050});
    exc <= 1'b1;
    meset <= 1'b1;
    @(posedge clk);
    meset <= 1'b0;
    @(posedge clk);
    exc <= 1'b0;
    pw <= rccr_priv_wr_t'({1'b1, 3'h2, d});
    @(posedge clk);
    pw <= '0;
    rd(ADDR_SAVED, 1'b0, {16'hA020, d[15:0]});
    rd(ADDR_GPR_BASE + 12'h004, 1'b0, pc + 32'h8);
    meset <= 1'b1;
    @(posedge clk);
    meset <= 1'b0;
    xfer(1'b1, ADDR_STATUS, 32'h00000210);
    q_ev.push_back({PRIV_VECTOR, v[31:12], 12'h020});
    xfer(1'b1, ADDR_VECBASE, 32'h0);
    repeat (4) @(posedge clk);
    rd(ADDR_VECBASE, 1'b0, v & VECBASE_MASK);
    rd(12'h040, 1'b1, 32'h0);
    complete_run();
  end
endmodule : tb

bind rccr_core_regs rccr_core_regs_checker #(.IRQ_WIRED(IRQ_WIRED)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRIV_WR(PRIV_WR),
  .EXCEPTION_REQ(EXCEPTION_REQ), .IRQ_LINES(IRQ_LINES), .EVENT(EVENT), .PRIV_FAULT(PRIV_FAULT),
  .ICACHE_PURGE(ICACHE_PURGE), .ICACHE_FREEZE(ICACHE_FREEZE), .SQUASH_NEXT(SQUASH_NEXT));
`default_nettype wire
